/* design/pag_pkg.sv */
// Purpose : shared constants and types of the pulse accumulator with gated timer
// Assumes : 32-bit classic wishbone register bus, byte addresses, one word per register
// Notes   : every offset, field position and cycle count, and the count, control, divider and lockout reset values live here
package pag_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_COUNT = 4'h0;  // accumulator_count_reg
    localparam logic [3:0] ADDR_CTRL  = 4'h4;  // mode, polarity, enables, prescale
    localparam logic [3:0] ADDR_FLAGS = 4'h8;  // timer_flag_reg_two
    localparam logic [3:0] ADDR_PIN   = 4'hc;  // live pin level

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CTRL_ENABLE_BIT    = 0;
    localparam int CTRL_GATED_BIT     = 1;
    localparam int CTRL_EDGE_SEL_BIT  = 2;
    localparam int CTRL_EDGE_IE_BIT   = 3;
    localparam int CTRL_WRAP_IE_BIT   = 4;
    localparam int CTRL_PRESCALE_LSB  = 8;
    localparam int FLAG_WRAP_BIT      = 4;
    localparam int FLAG_EDGE_BIT      = 5;
    localparam int PIN_LEVEL_BIT      = 0;

    // ------------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------------
    localparam logic [7:0] COUNT_RESET    = 8'h00;
    localparam logic [1:0] PRESCALE_RESET = 2'h0;
    localparam int         TICK_DIVIDE    = 64;  // bus cycles per gated tick
    localparam int         EDGE_LOCKOUT   = 2;   // bus cycles between recognised edges
    localparam logic [5:0] DIV_RESET      = 6'h00;
    localparam logic [1:0] LOCK_RESET     = 2'h0;

    // ------------------------------------------------------------------
    // control fields carried together
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] timer_prescale_select;
        logic       count_wrap_irq_enable;
        logic       input_edge_irq_enable;
        logic       edge_level_select;
        logic       gated_mode;
        logic       enable;
    } pag_ctrl_type;

    localparam pag_ctrl_type CTRL_RESET = '{
        timer_prescale_select : PRESCALE_RESET,
        count_wrap_irq_enable : 1'b0,
        input_edge_irq_enable : 1'b0,
        edge_level_select     : 1'b0,
        gated_mode            : 1'b0,
        enable                : 1'b0
    };

endpackage

/* design/pag_top.sv */
// Purpose : 8-bit pulse accumulator, event counting or gated time accumulation
// Assumes : one clock, clk_i is the bus clock and each rising edge stands for a
//           phase-two falling edge; synchronous active-high reset
// Notes   : registers reached over classic wishbone; ack comes one cycle after
//           the request and writes take effect on the ack edge
//
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - gated mode counts every 64th cycle while active
// - select bit names the level that stops counting
// - count holds when inactive, resumes later
// - gated trailing edge sets edge flag, own irq
// - wrap from ff to 00 sets flag same edge
// - counter stops at trailing edge, wrap flagged
// - pin synchronised, rate at most half clock
// - recognised edge sets edge flag next edge
// - event mode increments with the edge flag
// - no second edge within two cycles
// - tick is free running, never restarted
// - tick tap follows prescale select bits
// - bus access never collides with counting
// - pin level readable at any time
// - edge interrupt on chosen rising or falling
// - local enable and global mask gate interrupt
// - edge flag readable, software clear cancels
// - writing one to bit 4 clears wrap
// - writing one to bit 5 clears edge
// - wrap irq when flag set and enabled
module pag_top #(
    parameter int COUNT_WIDTH = 8
) (
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // wishbone slave
    input  wire logic                   cyc_i,
    input  wire logic                   stb_i,
    input  wire logic                   we_i,
    input  wire logic [3:0]             adr_i,
    input  wire logic [3:0]             sel_i,
    input  wire logic [31:0]            dat_i,
    output logic      [31:0]            dat_o,
    output logic                        ack_o,
    // pin and processor side
    input  wire logic                   pulse_input_pin_i,
    input  wire logic                   global_irq_mask_i,
    output logic                        input_edge_irq_o,
    output logic                        count_wrap_irq_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    // count and control
    logic [COUNT_WIDTH-1:0]  accumulator_count_reg;
    logic [COUNT_WIDTH-1:0]  accumulator_count_next;
    pag_pkg::pag_ctrl_type   ctrl_reg;
    pag_pkg::pag_ctrl_type   ctrl_next;

    // sticky flags
    logic                    input_edge_flag_reg;
    logic                    input_edge_flag_next;
    logic                    count_wrap_flag_reg;
    logic                    count_wrap_flag_next;

    // pin path
    logic [2:0]              pin_sync_reg;
    logic                    pin_level_reg;
    logic                    pin_level_next;

    // divider and lockout
    logic [5:0]              div_reg;
    logic [1:0]              lock_reg;
    logic [1:0]              lock_next;

    // bus answer
    logic                    ack_reg;
    logic [31:0]             dat_reg;
    logic [31:0]             dat_next;

    // interrupt requests
    logic                    edge_irq_reg;
    logic                    wrap_irq_reg;

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------
    // tap point of the divide-by-64 tick within the shared divider chain
    function automatic logic [5:0] tick_phase(input logic [1:0] prescale);
        logic [5:0] phase;
        phase = 6'h3f;
        unique case (prescale)
            2'h0: phase = 6'h3f;
            2'h1: phase = 6'h3c;
            2'h2: phase = 6'h38;
            2'h3: phase = 6'h30;
        endcase
        return phase;
    endfunction

    // byte-lane merge of a write into a 32-bit word
    function automatic logic [31:0] lane_merge(input logic [31:0] old_word,
                                               input logic [31:0] new_word,
                                               input logic [3:0]  lanes);
        logic [31:0] merged;
        merged = old_word;
        for (int i = 0; i < 4; i++) begin
            if (lanes[i]) begin
                merged[i*8 +: 8] = new_word[i*8 +: 8];
            end
        end
        return merged;
    endfunction

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    // the write is applied at the ack edge, the only edge the master samples
    wire logic        bus_req;
    wire logic        wr_now;
    wire logic        wr_count;
    wire logic        wr_ctrl;
    wire logic        wr_flags;

    wire logic [31:0] ctrl_word;
    wire logic [31:0] ctrl_merged;
    wire logic [31:0] count_word;
    wire logic [31:0] count_merged;

    wire logic        clr_wrap;
    wire logic        clr_edge;

    assign bus_req     = cyc_i & stb_i;
    assign wr_now      = bus_req & we_i & ack_reg;
    assign wr_count    = wr_now & (adr_i == pag_pkg::ADDR_COUNT);
    assign wr_ctrl     = wr_now & (adr_i == pag_pkg::ADDR_CTRL);
    assign wr_flags    = wr_now & (adr_i == pag_pkg::ADDR_FLAGS);

    // readback words
    assign ctrl_word   = {22'h000000, ctrl_reg.timer_prescale_select, 3'h0,
                          ctrl_reg.count_wrap_irq_enable, ctrl_reg.input_edge_irq_enable,
                          ctrl_reg.edge_level_select, ctrl_reg.gated_mode, ctrl_reg.enable};
    assign ctrl_merged = lane_merge(ctrl_word, dat_i, sel_i);
    assign count_word  = {{(32-COUNT_WIDTH){1'b0}}, accumulator_count_reg};
    assign count_merged = lane_merge(count_word, dat_i, sel_i);
    // clearing needs a one in the flag position; a zero leaves the flag alone
    assign clr_wrap    = wr_flags & sel_i[0] & dat_i[pag_pkg::FLAG_WRAP_BIT];
    assign clr_edge    = wr_flags & sel_i[0] & dat_i[pag_pkg::FLAG_EDGE_BIT];

    // ------------------------------------------------------------------
    // pin qualification and edge recognition
    // ------------------------------------------------------------------
    // a level change is accepted only when the second and third stages agree,
    // which also caps the usable count rate at half the bus clock
    wire logic pin_stable;
    wire logic pin_change;
    wire logic edge_seen;
    wire logic sel_edge;
    wire logic level_active;

    assign pin_stable   = (pin_sync_reg[1] == pin_sync_reg[2]);
    assign pin_change   = pin_stable & (pin_sync_reg[2] != pin_level_reg) & (lock_reg == 2'h0);
    assign pin_level_next = pin_change ? pin_sync_reg[2] : pin_level_reg;
    assign edge_seen    = pin_change;

    // the chosen edge ends on the level equal to the select bit; in gated mode
    // that same level is the one that inhibits counting, so it is the trailing edge
    assign sel_edge     = edge_seen & (pin_sync_reg[2] == ctrl_reg.edge_level_select);

    // active level is the opposite of the stopping level
    assign level_active = (pin_level_reg != ctrl_reg.edge_level_select);

    // lockout reloads on each accepted change
    assign lock_next    = edge_seen ? 2'(pag_pkg::EDGE_LOCKOUT - 1)
                        : ((lock_reg != pag_pkg::LOCK_RESET) ? lock_reg - 2'h1 : lock_reg);

    // ------------------------------------------------------------------
    // counting
    // ------------------------------------------------------------------
    // the divider never restarts with the pin, so the first tick of a pulse
    // may land anywhere within one 64-cycle period
    wire logic tick;
    wire logic gated_inc;
    wire logic event_inc;
    wire logic count_inc;
    wire logic wraps;

    assign tick      = (div_reg == tick_phase(ctrl_reg.timer_prescale_select));

    // the level register only turns inactive at the trailing edge, so counting
    // stops there and a last tick before it still counts and may wrap
    assign gated_inc = ctrl_reg.gated_mode & level_active & tick;
    assign event_inc = ~ctrl_reg.gated_mode & sel_edge;
    assign count_inc = ctrl_reg.enable & (gated_inc | event_inc) & ~wr_count;
    assign wraps     = count_inc & (&accumulator_count_reg);

    // a software write wins over an increment in the same cycle, so an access
    // and a count update can never mix into one value
    assign accumulator_count_next = wr_count ? count_merged[COUNT_WIDTH-1:0]
                                  : (count_inc ? accumulator_count_reg + 1'b1
                                               : accumulator_count_reg);

    // ------------------------------------------------------------------
    // flags and control
    // ------------------------------------------------------------------
    // set wins over a clear arriving in the same cycle
    wire logic edge_set;

    assign edge_set             = ctrl_reg.enable & sel_edge;
    assign input_edge_flag_next = edge_set | (input_edge_flag_reg & ~clr_edge);
    assign count_wrap_flag_next = wraps | (count_wrap_flag_reg & ~clr_wrap);

    assign ctrl_next = wr_ctrl ? pag_pkg::pag_ctrl_type'{
                           timer_prescale_select :
                               ctrl_merged[pag_pkg::CTRL_PRESCALE_LSB +: 2],
                           count_wrap_irq_enable : ctrl_merged[pag_pkg::CTRL_WRAP_IE_BIT],
                           input_edge_irq_enable : ctrl_merged[pag_pkg::CTRL_EDGE_IE_BIT],
                           edge_level_select     : ctrl_merged[pag_pkg::CTRL_EDGE_SEL_BIT],
                           gated_mode            : ctrl_merged[pag_pkg::CTRL_GATED_BIT],
                           enable                : ctrl_merged[pag_pkg::CTRL_ENABLE_BIT]
                       } : ctrl_reg;

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    // unmapped offsets read as zero and are still acknowledged
    wire logic [31:0] flags_word;
    wire logic [31:0] pin_word;
    wire logic [31:0] read_word;

    assign flags_word = 32'(count_wrap_flag_reg) << pag_pkg::FLAG_WRAP_BIT
                      | 32'(input_edge_flag_reg) << pag_pkg::FLAG_EDGE_BIT;

    // the qualified level is readable whatever mode or enable is set
    assign pin_word   = 32'(pin_level_reg) << pag_pkg::PIN_LEVEL_BIT;
    assign read_word  = (adr_i == pag_pkg::ADDR_COUNT) ? count_word
                      : (adr_i == pag_pkg::ADDR_CTRL)  ? ctrl_word
                      : (adr_i == pag_pkg::ADDR_FLAGS) ? flags_word
                      : (adr_i == pag_pkg::ADDR_PIN)   ? pin_word
                      : 32'h00000000;

    // held until the next read is taken
    assign dat_next   = (bus_req & ~we_i & ~ack_reg) ? read_word : dat_reg;

    // ------------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------------
    // stage one is read only by stage two
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_sync_reg <= 3'h0;
        end else begin
            pin_sync_reg <= {pin_sync_reg[1:0], pulse_input_pin_i};
        end
    end

    // ------------------------------------------------------------------
    // free-running divider chain
    // ------------------------------------------------------------------
    // every tap is a phase of this one chain
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_reg <= pag_pkg::DIV_RESET;
        end else begin
            div_reg <= div_reg + 6'h01;
        end
    end

    // ------------------------------------------------------------------
    // edge detector and counter
    // ------------------------------------------------------------------
    // level, lockout and count share an edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_level_reg         <= 1'b0;
            lock_reg              <= pag_pkg::LOCK_RESET;
            accumulator_count_reg <= COUNT_WIDTH'(pag_pkg::COUNT_RESET);
        end else begin
            pin_level_reg         <= pin_level_next;
            lock_reg              <= lock_next;
            accumulator_count_reg <= accumulator_count_next;
        end
    end

    // ------------------------------------------------------------------
    // flags and control register
    // ------------------------------------------------------------------
    // flags stay set until written with ones
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            input_edge_flag_reg <= 1'b0;
            count_wrap_flag_reg <= 1'b0;
            ctrl_reg            <= pag_pkg::CTRL_RESET;
        end else begin
            input_edge_flag_reg <= input_edge_flag_next;
            count_wrap_flag_reg <= count_wrap_flag_next;
            ctrl_reg            <= ctrl_next;
        end
    end

    // ------------------------------------------------------------------
    // interrupt requests
    // ------------------------------------------------------------------
    // enables gate only the requests, never the flags; a global mask from the
    // processor holds both off without touching pending state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            edge_irq_reg <= 1'b0;
            wrap_irq_reg <= 1'b0;
        end else begin
            edge_irq_reg <= input_edge_flag_next & ctrl_next.input_edge_irq_enable
                          & ~global_irq_mask_i;
            wrap_irq_reg <= count_wrap_flag_next & ctrl_next.count_wrap_irq_enable
                          & ~global_irq_mask_i;
        end
    end

    // ------------------------------------------------------------------
    // wishbone answer
    // ------------------------------------------------------------------
    // ack rises one cycle after the request and drops the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
            dat_reg <= dat_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // no logic between registers and pins
    assign dat_o            = dat_reg;
    assign ack_o            = ack_reg;
    assign input_edge_irq_o = edge_irq_reg;
    assign count_wrap_irq_o = wrap_irq_reg;

endmodule

`default_nettype wire

/* dv/pag_chk.sv */
// Purpose : port-level assertions for the pulse accumulator
// Assumes : one clock domain, synchronous active-high reset
// Notes   : bound to every pag_top instance at the foot of this file
`timescale 1ns/10ps
`default_nettype none

module pag_chk #(
    parameter int COUNT_WIDTH = 8
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    input  wire logic [31:0] dat_o,
    input  wire logic        ack_o,
    // pin and interrupt side
    input  wire logic        pulse_input_pin_i,
    input  wire logic        global_irq_mask_i,
    input  wire logic        input_edge_irq_o,
    input  wire logic        count_wrap_irq_o
);
    // ------------------------------------------------------------------
    // one clock, so clocking and disable are declared once
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // bus answers exactly one cycle after a request, never longer
    a_ack_follows_req: assert property (
        cyc_i && stb_i && !ack_o |=> ack_o) else $error("request not acked");
    a_ack_single: assert property (
        ack_o |=> !ack_o) else $error("ack longer than one cycle");

    // global mask holds both requests off
    a_irq_masked: assert property (
        global_irq_mask_i && $past(global_irq_mask_i) |-> !input_edge_irq_o && !count_wrap_irq_o)
        else $error("irq while masked");

    // a pin held steady reads back as its level
    a_pin_readback: assert property (
        ack_o && !we_i && adr_i == pag_pkg::ADDR_PIN
        && $past(pulse_input_pin_i, 3) == pulse_input_pin_i
        && $past(pulse_input_pin_i, 6) == pulse_input_pin_i
        |-> dat_o[0] == pulse_input_pin_i) else $error("pin level misread");

    // edge irq can only move after a synchronised pin change, a bus write or a change of the global mask
    a_edge_irq_quiet: assert property (
        ($stable(pulse_input_pin_i) && !ack_o && $stable(global_irq_mask_i))[*8]
        |=> $stable(input_edge_irq_o)) else $error("edge irq moved without cause");

    // write-one clears drop the matching request on the ack edge; a zero in bit 4 keeps the wrap request
    a_wrap_clear: assert property (
        ack_o && we_i && adr_i == pag_pkg::ADDR_FLAGS && sel_i[0] && dat_i[4]
        |=> !count_wrap_irq_o) else $error("wrap irq survived clear");
    a_edge_clear: assert property (
        ack_o && we_i && adr_i == pag_pkg::ADDR_FLAGS && sel_i[0] && dat_i[5]
        |=> !input_edge_irq_o) else $error("edge irq survived clear");
    a_wrap_zero_keeps: assert property (
        (ack_o && we_i && adr_i == pag_pkg::ADDR_FLAGS && !dat_i[4] && count_wrap_irq_o
        && !global_irq_mask_i) ##1 !global_irq_mask_i |-> count_wrap_irq_o)
        else $error("wrap irq lost on zero write");
endmodule

bind pag_top pag_chk #(.COUNT_WIDTH(COUNT_WIDTH)) chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .pulse_input_pin_i(pulse_input_pin_i), .global_irq_mask_i(global_irq_mask_i),
    .input_edge_irq_o(input_edge_irq_o), .count_wrap_irq_o(count_wrap_irq_o));
`default_nettype wire

/* dv/pag_pulse_src.sv */
// Purpose : external pulse source driving the accumulator pin
// Assumes : bench clock, pulses of at least two cycles per level
// Notes   : pin rests at idle_level_i and inverts for len_i cycles per fire
`timescale 1ns/10ps
`default_nettype none

module pag_pulse_src (
    // clock
    input  wire logic        clk_i,
    // control from the bench
    input  wire logic        idle_level_i,
    input  wire logic        fire_i,
    input  wire logic [15:0] len_i,
    // pin and status
    output logic             pin_o,
    output logic             busy_o
);
    logic [15:0] left_reg = 16'h0000;

    // count out the pulse; lengths of two or more keep within the half-rate limit
    always_ff @(posedge clk_i) begin
        if (fire_i) begin
            left_reg <= len_i;
        end else if (left_reg != 16'h0000) begin
            left_reg <= left_reg - 16'h0001;
        end
    end

    assign busy_o = (left_reg != 16'h0000);
    assign pin_o  = busy_o ? ~idle_level_i : idle_level_i;
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// Purpose : register-level tests of the pulse accumulator
// Assumes : 50 MHz clock, wishbone master holds each request until ack
// Notes   : all expectations derive from tick and flag rules
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    // ------------------------------------------------------------------
    // stimulus and status
    // ------------------------------------------------------------------
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [3:0]  adr_i = 4'h0;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        global_irq_mask_i = 1'b0;
    logic        input_edge_irq_o;
    logic        count_wrap_irq_o;
    logic        idle_lvl = 1'b0;
    logic        fire = 1'b0;
    logic [15:0] plen = 16'h0004;
    logic [31:0] rd;
    logic [31:0] e;
    wire logic   pin;
    wire logic   busy;
    int          fail_count = 0;
    int          num_checks = 0;
    int          cyc_cnt = 0;

    always #10 clk_i = ~clk_i;

    pag_top #(.COUNT_WIDTH(8)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .pulse_input_pin_i(pin), .global_irq_mask_i(global_irq_mask_i),
        .input_edge_irq_o(input_edge_irq_o), .count_wrap_irq_o(count_wrap_irq_o));

    pag_pulse_src src_u (.clk_i(clk_i), .idle_level_i(idle_lvl), .fire_i(fire),
        .len_i(plen), .pin_o(pin), .busy_o(busy));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one classic cycle; held until ack is sampled high
    task automatic wb_xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= 4'hf;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1) begin
            @(posedge clk_i);
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        wb_xfer(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        wb_xfer(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    // fire one pulse and let it pass the synchroniser
    task automatic pulse(input logic [15:0] n);
        @(posedge clk_i);
        plen <= n;
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
        @(posedge clk_i);
        while (busy === 1'b1) begin
            @(posedge clk_i);
        end
        repeat (8) @(posedge clk_i);
    endtask

    // hang guard, well above the roughly 1500 cycles the tests need
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 8000) begin
            fail_count++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(pag_pkg::ADDR_COUNT, 32'h0);
        rd_chk(pag_pkg::ADDR_CTRL, 32'h0);
        rd_chk(pag_pkg::ADDR_FLAGS, 32'h0);
        rd_chk(pag_pkg::ADDR_PIN, 32'h0);
        rd_chk(4'h2, 32'h0);
        $display("test reset done");
        // event mode on rising edges, preloaded to wrap after three
        wr(pag_pkg::ADDR_CTRL, 32'h5);
        wr(pag_pkg::ADDR_COUNT, 32'hfd);
        repeat (3) pulse(16'h0004);
        rd_chk(pag_pkg::ADDR_COUNT, 32'h0);
        rd_chk(pag_pkg::ADDR_FLAGS, 32'h30);
        wr(pag_pkg::ADDR_CTRL, 32'h1d);
        @(posedge clk_i);
        check({30'h0, input_edge_irq_o, count_wrap_irq_o}, 32'h3);
        global_irq_mask_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        check({30'h0, input_edge_irq_o, count_wrap_irq_o}, 32'h0);
        global_irq_mask_i <= 1'b0;
        wr(pag_pkg::ADDR_FLAGS, 32'h0);
        @(posedge clk_i);
        check({30'h0, input_edge_irq_o, count_wrap_irq_o}, 32'h3);
        wr(pag_pkg::ADDR_FLAGS, 32'h10);
        rd_chk(pag_pkg::ADDR_FLAGS, 32'h20);
        wr(pag_pkg::ADDR_FLAGS, 32'h20);
        rd_chk(pag_pkg::ADDR_FLAGS, 32'h0);
        wr(pag_pkg::ADDR_CTRL, 32'h19);
        pulse(16'h0004);
        rd_chk(pag_pkg::ADDR_COUNT, 32'h1);
        check({30'h0, input_edge_irq_o, count_wrap_irq_o}, 32'h2);
        wr(pag_pkg::ADDR_FLAGS, 32'h30);
        $display("test event done");
        // gated, active high: 320 cycles hold exactly five ticks
        wr(pag_pkg::ADDR_CTRL, 32'h3);
        wr(pag_pkg::ADDR_COUNT, 32'h0);
        pulse(16'h0140);
        rd_chk(pag_pkg::ADDR_COUNT, 32'h5);
        rd_chk(pag_pkg::ADDR_FLAGS, 32'h20);
        repeat (100) @(posedge clk_i);
        rd_chk(pag_pkg::ADDR_COUNT, 32'h5);
        e = 32'h5;
        for (int p = 0; p < 4; p++) begin
            wr(pag_pkg::ADDR_CTRL, 32'h3 | (32'(p) << 8));
            pulse(16'h0080);
            e = e + 32'h2;
            rd_chk(pag_pkg::ADDR_COUNT, e);
        end
        wr(pag_pkg::ADDR_COUNT, 32'hfe);
        wr(pag_pkg::ADDR_FLAGS, 32'h30);
        pulse(16'h0080);
        rd_chk(pag_pkg::ADDR_COUNT, 32'h0);
        rd_chk(pag_pkg::ADDR_FLAGS, 32'h30);
        // gated, active low: idle high stops counting
        wr(pag_pkg::ADDR_CTRL, 32'h6);
        idle_lvl <= 1'b1;
        repeat (8) @(posedge clk_i);
        rd_chk(pag_pkg::ADDR_PIN, 32'h1);
        wr(pag_pkg::ADDR_FLAGS, 32'h30);
        wr(pag_pkg::ADDR_CTRL, 32'h7);
        wr(pag_pkg::ADDR_COUNT, 32'h0);
        pulse(16'h00c0);
        rd_chk(pag_pkg::ADDR_COUNT, 32'h3);
        rd_chk(pag_pkg::ADDR_FLAGS, 32'h20);
        $display("test gated done");
        wrap_up();
    end
endmodule
`default_nettype wire
